// File: inc/umsc_pkg.sv
// constants and types shared by the serial channel files
package umsc_pkg;
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_CTRL0 = 4'h1;
    localparam logic [3:0] OFS_CTRL1 = 4'h2;
    localparam logic [3:0] OFS_SMA = 4'h3;
    localparam logic [3:0] OFS_SMB = 4'h4;
    localparam logic [3:0] OFS_SMC = 4'h5;
    localparam logic [3:0] OFS_SMD = 4'h6;
    localparam logic [3:0] OFS_BRG = 4'h7;
    localparam logic [3:0] OFS_TB = 4'h8;
    localparam logic [3:0] OFS_RB = 4'h9;
    localparam logic [3:0] OFS_UPPER = 4'ha;
    localparam logic [3:0] OFS_PINSEL = 4'hb;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_CLOCK_DIRECTION_SEL = 3;
    localparam int MODE_STOP_LENGTH_SEL = 4;
    localparam int MODE_PRY = 5;
    localparam int MODE_PARITY_ON = 6;
    localparam int MODE_POL = 7;
    localparam int C0_SHIFT_REG_EMPTY = 3;
    localparam int C0_CRD = 4;
    localparam int C0_NCH = 5;
    localparam int C0_BIT_ORDER_SEL = 7;
    localparam int C1_TE = 0;
    localparam int C1_TI = 1;
    localparam int C1_RE = 2;
    localparam int C1_RI = 3;
    localparam int C1_IRS = 4;
    localparam int C1_RRM = 5;
    localparam int C1_LCH = 6;
    localparam int RB_OER = 12;
    localparam int RB_FER = 13;
    localparam int RB_PER = 14;
    localparam int RB_SUM = 15;
    localparam logic [7:0] C0_WMASK = 8'hf3;
    localparam logic [7:0] C1_WMASK = 8'h75;
    // ------------------------------------------------------------
    // modes, sources, reset values, counts
    // ------------------------------------------------------------
    localparam logic [2:0] SMD_A7 = 3'h4;
    localparam logic [2:0] SMD_A8 = 3'h5;
    localparam logic [2:0] SMD_A9 = 3'h6;
    localparam logic [1:0] CS_F1 = 2'h0;
    localparam logic [1:0] CS_F8 = 2'h1;
    localparam int F2N_LOG = 5;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } umsc_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } umsc_rx_st_t;
endpackage

// File: inc/umsc_brg_if.sv
// link between the channel core and its bit-rate generator
`timescale 1ns/1ps
interface umsc_brg_if;
    logic [7:0] divider;
    logic [1:0] src_sel;
    logic ext_sel;
    logic ext_lvl;
    logic run;
    logic tick;
    modport core (output divider, src_sel, ext_sel, ext_lvl, run,
        input tick);
    modport gen (input divider, src_sel, ext_sel, ext_lvl, run,
        output tick);
endinterface

// File: hdl/umsc_brg.sv
// bit-rate generator: one tick per sixteenth of a bit
`timescale 1ns/1ps
module umsc_brg
    import umsc_pkg::*;
#(
    parameter int F2N_BITS = F2N_LOG
) (
    input wire logic clk,
    input wire logic nrst,
    umsc_brg_if.gen brg
);
    logic [7:0] pre_q;
    logic [7:0] cnt_q;
    logic ext_prev_q;
    logic tick_q;
    logic src_pulse;

    // ------------------------------------------------------------
    // count source
    // ------------------------------------------------------------
    // internal or external
    always_comb begin
        if (brg.ext_sel) begin
            src_pulse = brg.ext_lvl & ~ext_prev_q;
        end else begin
            case (brg.src_sel)
                CS_F1: src_pulse = 1'b1;
                CS_F8: src_pulse = &pre_q[2:0];
                default: src_pulse = &pre_q[F2N_BITS-1:0];
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_q <= RST_REG8;
            ext_prev_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 8'h01;
            ext_prev_q <= brg.ext_lvl;
        end
    end

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // divide by m plus one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= RST_REG8;
            tick_q <= 1'b0;
        end else if (!brg.run) begin
            cnt_q <= brg.divider;
            tick_q <= 1'b0;
        end else begin
            tick_q <= src_pulse && cnt_q == 8'h00;
            if (src_pulse) begin
                cnt_q <= (cnt_q == 8'h00) ? brg.divider : cnt_q - 8'h01;
            end
        end
    end

    assign brg.tick = tick_q;
endmodule

// File: hdl/umsc_core.sv
// asynchronous serial channel with register port
//
// Functional notes
// - receive buffer data undefined after overrun
// - overrun raises no receive interrupt
// - transmit output idles high once mode set
// - open-drain idle leaves pin undriven
// - mode codes select 7, 8, 9 bits
// - bit order only for 8-bit characters
// - data sits in low-order bits
// - parity enable and odd/even select
// - stop-length bit sets one or two
// - clock from generator or external pin
// - count source feeds 8-bit generator
// - flow-disable bit clear lets clear-to-send gate transmit
// - shift-register-empty flag readable
// - transmit-buffer-empty flag readable
// - error flags in receive buffer high bits
// - enable bits gate receive and transmit
// - transmit interrupt source select
// - data inversion on channels 0-2
// - pin polarity inversion on channels 0-2
// - push-pull or open-drain on channels 0-2
// - input pin routing for channels 3, 4
// - bit rate is source over 16(m+1)
// - transmit start conditions
// - overrun timing on bit before stop
// - clear-to-send high stops next character
`timescale 1ns/1ps
module umsc_core
    import umsc_pkg::*;
#(
    parameter int CHAN = 0
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [umsc_pkg::AW-1:0] ADDR,
    input wire logic [umsc_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [umsc_pkg::DW-1:0] RDATA,
    input wire logic [3:0] SERIAL_IN,
    input wire logic [3:0] EXT_CLK,
    input wire logic [3:0] FLOW_CTRL_N,
    output logic TXD_O,
    output logic TXD_OE,
    output logic TX_IRQ,
    output logic RX_IRQ
);
    import umsc_pkg::*;

    localparam bit LOW_CH = CHAN <= 2;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] char_len(input logic [2:0] m);
        case (m)
            SMD_A7: char_len = 4'h7;
            SMD_A9: char_len = 4'h9;
            default: char_len = 4'h8;
        endcase
    endfunction

    function automatic logic [8:0] len_mask(input logic [3:0] n);
        len_mask = 9'h1ff >> (4'h9 - n);
    endfunction

    function automatic logic [8:0] rev8(input logic [8:0] v);
        rev8 = v;
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7-i];
        end
    endfunction

    function automatic logic par_of(input logic [8:0] d,
        input logic odd);
        par_of = (^d) ^ odd;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] c0_q;
    logic [7:0] c1_q;
    logic [7:0] sm_q [0:3];
    logic [7:0] brg_q;
    logic [8:0] tb_q;
    logic [15:0] rb_q;
    logic [7:0] upper_q;
    logic [7:0] pinsel_q;
    logic tbe_q;
    logic ri_q;
    logic [15:0] rdata_d;
    logic wr_tb;
    logic rd_rb;

    assign wr_tb = WR && ADDR == OFS_TB;
    assign rd_rb = RD && ADDR == OFS_RB;

    logic mode_ok;
    assign mode_ok = mode_q[2:0] inside {SMD_A7, SMD_A8, SMD_A9};

    logic [3:0] len;
    logic [8:0] dmask;
    logic parity_on;
    logic stop_length_sel;
    logic pol;
    logic lch;
    logic open_drain_sel;
    logic irs;
    logic bit_order_sel;
    logic te;
    logic re;
    logic [1:0] route;

    assign len = char_len(mode_q[2:0]);
    assign dmask = len_mask(len);
    assign parity_on = mode_q[MODE_PARITY_ON];
    assign stop_length_sel = mode_q[MODE_STOP_LENGTH_SEL];
    assign te = c1_q[C1_TE];
    assign re = c1_q[C1_RE];
    assign bit_order_sel = c0_q[C0_BIT_ORDER_SEL] && len == 4'h8;
    assign pol = LOW_CH && mode_q[MODE_POL];
    assign lch = LOW_CH && c1_q[C1_LCH];
    assign open_drain_sel = LOW_CH && c0_q[C0_NCH];
    assign irs = LOW_CH ? c1_q[C1_IRS] : upper_q[CHAN == 4];
    assign route = CHAN == 3 ? pinsel_q[3:2] :
                   CHAN == 4 ? pinsel_q[5:4] : 2'h0;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            mode_q <= RST_REG8;
            c0_q <= RST_REG8;
            c1_q <= RST_REG8;
            brg_q <= RST_REG8;
            upper_q <= RST_REG8;
            pinsel_q <= RST_REG8;
            for (int i = 0; i < 4; i++) begin
                sm_q[i] <= RST_REG8;
            end
        end else if (WR) begin
            case (ADDR)
                OFS_MODE: mode_q <= WDATA[7:0];
                OFS_CTRL0: c0_q <= WDATA[7:0] & C0_WMASK;
                OFS_CTRL1: c1_q <= WDATA[7:0] & C1_WMASK;
                OFS_SMA: sm_q[0] <= WDATA[7:0];
                OFS_SMB: sm_q[1] <= WDATA[7:0];
                OFS_SMC: sm_q[2] <= WDATA[7:0];
                OFS_SMD: sm_q[3] <= WDATA[7:0];
                OFS_BRG: brg_q <= WDATA[7:0];
                OFS_UPPER: upper_q <= WDATA[7:0];
                OFS_PINSEL: pinsel_q <= WDATA[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0] sin_s1_q;
    logic [3:0] sin_s2_q;
    logic [3:0] ext_s1_q;
    logic [3:0] ext_s2_q;
    logic [3:0] cts_s1_q;
    logic [3:0] cts_s2_q;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sin_s1_q <= 4'hf;
            sin_s2_q <= 4'hf;
            ext_s1_q <= 4'h0;
            ext_s2_q <= 4'h0;
            cts_s1_q <= 4'hf;
            cts_s2_q <= 4'hf;
        end else begin
            sin_s1_q <= SERIAL_IN;
            sin_s2_q <= sin_s1_q;
            ext_s1_q <= EXT_CLK;
            ext_s2_q <= ext_s1_q;
            cts_s1_q <= FLOW_CTRL_N;
            cts_s2_q <= cts_s1_q;
        end
    end

    // ------------------------------------------------------------
    // bit-rate generator
    // ------------------------------------------------------------
    umsc_brg_if brg_bus ();
    logic tick;

    assign brg_bus.divider = brg_q;
    assign brg_bus.src_sel = c0_q[1:0];
    assign brg_bus.ext_sel = mode_q[MODE_CLOCK_DIRECTION_SEL];
    assign brg_bus.ext_lvl = ext_s2_q[route];
    assign brg_bus.run = mode_ok;
    assign tick = brg_bus.tick;

    umsc_brg u_brg (
        .clk(CLK),
        .nrst(NRST),
        .brg(brg_bus)
    );

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    umsc_tx_st_t tx_st_q;
    logic [12:0] tx_fr_q;
    logic [12:0] tx_fr_d;
    logic [3:0] tx_nb_q;
    logic [3:0] tx_idx_q;
    logic [3:0] tx_cnt_q;
    logic [8:0] tx_dat;
    logic tx_par;
    logic tx_load;
    logic tx_done;
    logic tx_line;
    logic cts_ok;

    assign cts_ok = c0_q[C0_CRD] || !cts_s2_q[route];
    assign tx_load = tx_st_q == TX_IDLE && mode_ok && te && !tbe_q
        && cts_ok;
    assign tx_done = tx_st_q == TX_SHIFT && tick
        && tx_cnt_q == OVS_LAST && tx_idx_q == tx_nb_q;

    always_comb begin
        tx_dat = tb_q & dmask;
        if (bit_order_sel) begin
            tx_dat = rev8(tx_dat);
        end
        tx_par = par_of(tx_dat, mode_q[MODE_PRY]);
        if (lch) begin
            tx_dat = ~tx_dat & dmask;
        end
        tx_fr_d = 13'h1fff;
        tx_fr_d[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < len) begin
                tx_fr_d[i+1] = tx_dat[i];
            end
        end
        if (parity_on) begin
            tx_fr_d[len+4'h1] = tx_par;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tx_st_q <= TX_IDLE;
            tx_fr_q <= 13'h1fff;
            tx_nb_q <= 4'h0;
            tx_idx_q <= 4'h0;
            tx_cnt_q <= 4'h0;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_st_q <= TX_SHIFT;
                        tx_fr_q <= tx_fr_d;
                        tx_nb_q <= len + 4'(parity_on) + 4'(stop_length_sel) + 4'h1;
                        tx_idx_q <= 4'h0;
                        tx_cnt_q <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    if (!mode_ok || tx_done) begin
                        tx_st_q <= TX_IDLE;
                    end else if (tick) begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (tx_cnt_q == OVS_LAST) begin
                            tx_idx_q <= tx_idx_q + 4'h1;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // cleared by write, set on load
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tbe_q <= 1'b1;
            tb_q <= RST_WORD[8:0];
        end else begin
            if (wr_tb) begin
                tb_q <= WDATA[8:0];
            end
            if (!mode_ok) begin
                tbe_q <= 1'b1;
            end else if (wr_tb) begin
                tbe_q <= 1'b0;
            end else if (tx_load) begin
                tbe_q <= 1'b1;
            end
        end
    end

    assign tx_line = tx_st_q == TX_SHIFT ? tx_fr_q[tx_idx_q] : 1'b1;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            TXD_O <= 1'b1;
            TXD_OE <= 1'b0;
            TX_IRQ <= 1'b0;
        end else begin
            if (open_drain_sel) begin
                TXD_O <= 1'b0;
                TXD_OE <= mode_ok && !(tx_line ^ pol);
            end else begin
                TXD_O <= tx_line ^ pol;
                TXD_OE <= mode_ok;
            end
            TX_IRQ <= irs ? tx_done : tx_load;
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    umsc_rx_st_t rx_st_q;
    logic [12:0] rx_sh_q;
    logic [12:0] rx_all;
    logic [3:0] rx_idx_q;
    logic [3:0] rx_cnt_q;
    logic rx_prev_q;
    logic rx_ovr_q;
    logic rx_lvl;
    logic rx_samp;
    logic rx_last;
    logic [3:0] rx_nb;
    logic [3:0] ovr_idx;
    logic [8:0] rx_dat;
    logic rx_perr;
    logic rx_ferr;

    assign rx_lvl = sin_s2_q[route] ^ pol;
    assign rx_nb = len + 4'(parity_on) + 4'(stop_length_sel);
    // bit before stop, or first stop
    assign ovr_idx = len + 4'(parity_on) + 4'(stop_length_sel) - 4'h1;
    assign rx_samp = rx_st_q == RX_DATA && tick && rx_cnt_q == OVS_LAST;
    assign rx_last = rx_samp && rx_idx_q == rx_nb;

    always_comb begin
        rx_all = rx_sh_q;
        rx_all[rx_idx_q] = rx_lvl;
        rx_dat = rx_all[8:0] & dmask;
        if (lch) begin
            rx_dat = ~rx_dat & dmask;
        end
        rx_perr = parity_on && par_of(rx_dat, mode_q[MODE_PRY]) != rx_all[len];
        rx_ferr = !rx_all[len+4'(parity_on)]
            || (stop_length_sel && !rx_all[len+4'(parity_on)+4'h1]);
        if (bit_order_sel) begin
            rx_dat = rev8(rx_dat);
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rx_st_q <= RX_IDLE;
            rx_sh_q <= 13'h0000;
            rx_idx_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_prev_q <= 1'b1;
            rx_ovr_q <= 1'b0;
        end else begin
            rx_prev_q <= rx_lvl;
            case (rx_st_q)
                RX_IDLE: begin
                    if (re && mode_ok && rx_prev_q && !rx_lvl) begin
                        rx_st_q <= RX_START;
                        rx_cnt_q <= 4'h0;
                    end
                end
                RX_START: begin
                    if (!re || !mode_ok) begin
                        rx_st_q <= RX_IDLE;
                    end else if (tick) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == OVS_MID) begin
                            rx_st_q <= rx_lvl ? RX_IDLE : RX_DATA;
                            rx_cnt_q <= 4'h0;
                            rx_idx_q <= 4'h0;
                            rx_ovr_q <= 1'b0;
                        end
                    end
                end
                RX_DATA: begin
                    if (!re || !mode_ok || rx_last) begin
                        rx_st_q <= RX_IDLE;
                    end else if (tick) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_samp) begin
                            rx_sh_q <= rx_all;
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q == ovr_idx && ri_q && !rd_rb) begin
                                rx_ovr_q <= 1'b1;
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive buffer and flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rb_q <= RST_WORD;
            ri_q <= 1'b0;
            RX_IRQ <= 1'b0;
        end else begin
            RX_IRQ <= 1'b0;
            if (!re) begin
                rb_q[15:12] <= 4'h0;
                ri_q <= 1'b0;
            end else if (rx_last && rx_ovr_q) begin
                rb_q[RB_OER] <= 1'b1;
                rb_q[RB_SUM] <= 1'b1;
            end else if (rx_last) begin
                rb_q <= {rx_perr || rx_ferr, rx_perr, rx_ferr, 4'h0,
                    rx_dat};
                ri_q <= 1'b1;
                RX_IRQ <= 1'b1;
            end else if (rd_rb) begin
                ri_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = RST_WORD;
        case (ADDR)
            OFS_MODE: rdata_d[7:0] = mode_q;
            OFS_CTRL0: rdata_d[7:0] = c0_q
                | {4'h0, tx_st_q == TX_IDLE, 3'h0};
            OFS_CTRL1: rdata_d[7:0] = c1_q
                | {4'h0, ri_q, 1'b0, tbe_q, 1'b0};
            OFS_SMA: rdata_d[7:0] = sm_q[0];
            OFS_SMB: rdata_d[7:0] = sm_q[1];
            OFS_SMC: rdata_d[7:0] = sm_q[2];
            OFS_SMD: rdata_d[7:0] = sm_q[3];
            OFS_BRG: rdata_d[7:0] = brg_q;
            OFS_RB: rdata_d = rb_q;
            OFS_UPPER: rdata_d[7:0] = upper_q;
            OFS_PINSEL: rdata_d[7:0] = pinsel_q;
            default: rdata_d = RST_WORD;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= RST_WORD;
        end else begin
            RDATA <= RD ? rdata_d : RST_WORD;
        end
    end
endmodule

// File: tb/umsc_monitor.sv
// port-level assertions for the serial channel
`timescale 1ns/1ps
module umsc_monitor
    import umsc_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [umsc_pkg::AW-1:0] ADDR,
    input wire logic [umsc_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [umsc_pkg::DW-1:0] RDATA,
    input wire logic TXD_O,
    input wire logic TXD_OE,
    input wire logic TX_IRQ,
    input wire logic RX_IRQ
);
    logic [7:0] mode_q;
    logic od_q;
    logic te_q;
    logic re_q;
    logic vld;
    // enables kept sticky: simpler, only weakens the checks later on
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            {mode_q, od_q, te_q, re_q} <= '0;
        end else if (WR) begin
            if (ADDR == OFS_MODE) mode_q <= WDATA[7:0];
            if (ADDR == OFS_CTRL0) od_q <= WDATA[C0_NCH];
            if (ADDR == OFS_CTRL1) te_q <= te_q | WDATA[C1_TE];
            if (ADDR == OFS_CTRL1) re_q <= re_q | WDATA[C1_RE];
        end
    end
    assign vld = !mode_q[MODE_POL] &&
        mode_q[2:0] inside {SMD_A7, SMD_A8, SMD_A9};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_rst_idle; disable iff (1'b0) !NRST |=> TXD_O && !TXD_OE;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("line not released after reset");
    property p_mode_idle; vld && !od_q && !te_q |=> TXD_O && TXD_OE;
    endproperty
    a_mode_idle: assert property (p_mode_idle)
        else $error("line not driven high while idle");
    property p_od_idle; vld && od_q && !te_q |=> !TXD_OE; endproperty
    a_od_idle: assert property (p_od_idle)
        else $error("open drain pin driven while idle");
    property p_no_txirq; !te_q |-> !TX_IRQ; endproperty
    a_no_txirq: assert property (p_no_txirq)
        else $error("transmit irq without transmit enable");
    property p_no_rxirq; !re_q |-> !RX_IRQ; endproperty
    a_no_rxirq: assert property (p_no_rxirq)
        else $error("receive irq without receive enable");
    property p_txirq_pulse; TX_IRQ |=> !TX_IRQ; endproperty
    a_txirq_pulse: assert property (p_txirq_pulse)
        else $error("transmit irq longer than one cycle");
    property p_rb_flags; RD && ADDR == OFS_RB |=>
        RDATA[11:9] == 3'h0 && RDATA[RB_SUM] == |RDATA[14:12]; endproperty
    a_rb_flags: assert property (p_rb_flags)
        else $error("receive buffer flags inconsistent");
    property p_ti_off; RD && ADDR == OFS_CTRL1 && mode_q[2:0] == 3'h0
        |=> RDATA[C1_TI]; endproperty
    a_ti_off: assert property (p_ti_off)
        else $error("buffer empty flag low with channel off");
endmodule
bind umsc_core umsc_monitor i_mon (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD_O(TXD_O),
    .TXD_OE(TXD_OE), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));

// File: tb/umsc_remote.sv
// far-end transceiver: drives receive data and clear-to-send
`timescale 1ns/1ps
module umsc_remote (
    input wire logic clk,
    input wire logic line,
    output logic rxd,
    output logic cts_n
);
    localparam int BIT = 16;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    task automatic set_cts(input logic hold);
        cts_n <= hold;
    endtask
    task automatic send(input logic [15:0] f, input int len);
        for (int i = 0; i < len; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
        // line rests at the last stop bit, no second drive per step
    endtask
    task automatic grab(input int len, output logic [15:0] v);
        int w;
        v = '1;
        w = 0;
        while (line !== 1'b0 && w < 3000) begin
            @(posedge clk);
            w++;
        end
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < len; i++) begin
            v[i] = line;
            repeat (BIT) @(posedge clk);
        end
    endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the serial channel
`timescale 1ns/1ps
module tb;
    import umsc_pkg::*;
    logic CLK = 0, NRST = 0, WR = 0, RD = 0;
    logic [AW-1:0] ADDR = '0;
    logic [DW-1:0] WDATA = '0, RDATA, v;
    logic TXD_O, TXD_OE, TX_IRQ, RX_IRQ, line, rxd, cts_n;
    logic [15:0] f;
    int n_fail = 0, checked = 0, cyc = 0, n_rx = 0, n_tx = 0;
    always #10 CLK = ~CLK;
    // released open-drain line floats to the pull-up
    assign line = TXD_OE ? TXD_O : 1'b1;
    umsc_core #(.CHAN(0)) i_dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .SERIAL_IN({3'h7, rxd}), .EXT_CLK(4'h0),
        .FLOW_CTRL_N({3'h7, cts_n}), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
        .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));
    umsc_remote i_rem (.clk(CLK), .line(line), .rxd(rxd), .cts_n(cts_n));
    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (RX_IRQ === 1'b1) n_rx <= n_rx + 1;
        if (TX_IRQ === 1'b1) n_tx <= n_tx + 1;
        if (cyc == 10000) begin
            n_fail++;
            stop_test;
        end
    end
    task automatic chk(input string s, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask
    // wire frame, first bit in bit 0; unused top bits stay at stop level
    function automatic logic [15:0] frm(input int n, input logic [8:0] d,
            input logic pe, input logic odd);
        logic [15:0] r;
        logic [8:0] m;
        m = d & 9'((1 << n) - 1);
        r = '1;
        r[0] = 1'b0;
        for (int i = 0; i < n; i++) r[i + 1] = m[i];
        if (pe) r[n + 1] = odd ^ (^m);
        return r;
    endfunction
    initial begin
        int n, pe, odd, st;
        logic [8:0] d;
        void'($urandom(58));
        repeat (20) @(posedge CLK);
        NRST <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk("reg", v, a == 1 ? 16'h8 : a == 2 ? 16'h2 : 16'h0);
        end
        wr(OFS_MODE, 16'h0045);
        wr(OFS_CTRL0, 16'h0020);
        repeat (4) @(posedge CLK);
        #1 chk("oe", {15'h0, TXD_OE}, 16'h0000);
        wr(OFS_CTRL0, 16'h0000);
        wr(OFS_CTRL1, 16'h0005);
        for (int k = 0; k < 6; k++) begin
            n = 7 + k % 3;
            pe = $urandom % 2;
            odd = $urandom % 2;
            st = k / 3;
            d = 9'($urandom);
            wr(OFS_MODE, 16'(n - 3 + st * 16 + odd * 32 + pe * 64));
            if (k == 0) i_rem.set_cts(1'b1);
            repeat (4) @(posedge CLK);
            wr(OFS_TB, 16'(d));
            if (k == 0) begin
                repeat (300) @(posedge CLK);
                #1 chk("cts", {15'h0, line}, 16'h0001);
                rd(OFS_CTRL0);
                chk("cts hold", v, 16'h0008);
                @(posedge CLK) i_rem.set_cts(1'b0);
            end
            i_rem.grab(n + pe + 2 + st, f);
            chk("tx", f, frm(n, d, pe[0], odd[0]));
            repeat (40) @(posedge CLK);
        end
        wr(OFS_MODE, 16'h0045);
        for (int k = 0; k < 4; k++) begin
            d = 9'($urandom % 256);
            f = frm(8, d, 1'b1, 1'b0);
            if (k == 1) f[9] = ~f[9];
            if (k == 2) wr(OFS_CTRL1, 16'h0001);
            if (k == 2) wr(OFS_CTRL1, 16'h0005);
            i_rem.send(f, 11);
            if (k < 2) rd(OFS_RB);
            if (k < 2) chk("rb", v, {k == 1 ? 4'hc : 4'h0, 3'h0, d});
        end
        repeat (20) @(posedge CLK);
        chk("rx irq", 16'(n_rx), 16'h0003);
        chk("tx irq", 16'(n_tx), 16'h0006);
        rd(OFS_RB);
        chk("overrun", v & 16'hf000, 16'h9000);
        stop_test;
    end
endmodule
